// File: rtl/tmr_defs.svh
// Register offsets, field positions and divider figures of the timer control block.
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TMR_OFS_CCR 6'h00
`define TMR_OFS_CMR 6'h04
`define TMR_OFS_CV 6'h10
`define TMR_OFS_RA 6'h14
`define TMR_OFS_RB 6'h18
`define TMR_OFS_RC 6'h1C
`define TMR_OFS_SR 6'h20
`define TMR_ADR_BCR 8'hC0
`define TMR_ADR_BMR 8'hC4

// ----------------------------------------------------------------------------
// Command and status bits
// ----------------------------------------------------------------------------
`define TMR_BCR_SYNC 0
`define TMR_CCR_ON 0
`define TMR_CCR_OFF 1
`define TMR_CCR_TRG 2
`define TMR_SR_CLKSTA 16
`define TMR_SR_MLINE_A 17
`define TMR_SR_MLINE_B 18

// ----------------------------------------------------------------------------
// Mode register fields, both views
// ----------------------------------------------------------------------------
`define TMR_M_CLKSRC 0
`define TMR_M_INV 3
`define TMR_M_GATE 4
`define TMR_M_STOP 6
`define TMR_M_OFF 7
`define TMR_M_EDGE 8
`define TMR_M_ABSEL 10
`define TMR_M_EVSRC 10
`define TMR_M_EVTRG 12
`define TMR_M_SHAPE 13
`define TMR_M_CTRG 14
`define TMR_M_WAVE 15
`define TMR_M_LDA 16
`define TMR_M_LDB 18
`define TMR_M_AMA 16
`define TMR_M_CMA 18
`define TMR_M_EVA 20
`define TMR_M_SWA 22
`define TMR_M_BMB 24
`define TMR_M_CMB 26
`define TMR_M_EVB 28
`define TMR_M_SWB 30

// ----------------------------------------------------------------------------
// Internal clock dividers, as low divider bits that must all be one
// ----------------------------------------------------------------------------
`define TMR_DIV_W 10
`define TMR_DIV1_BITS 1
`define TMR_DIV2_BITS 3
`define TMR_DIV3_BITS 5
`define TMR_DIV4_BITS 7
`define TMR_DIV5_BITS 10

`endif

// File: rtl/tmr_pkg.sv
// Types of the timer control block.
package tmr_pkg;

  typedef struct packed {
    logic [31:0] mode;
    logic [15:0] cv;
    logic [15:0] ra;
    logic [15:0] rb;
    logic [15:0] rc;
    logic clk_en;
    logic stopped;
    logic up;
    logic a_out;
    logic b_out;
    logic a_loaded;
  } tmr_chan_t;

  typedef struct packed {
    tmr_chan_t [2:0] ch;
    logic [5:0] ext_sel;
    logic [9:0] div;
    logic [2:0] clk_s1;
    logic [2:0] clk_s2;
    logic [2:0] a_s1;
    logic [2:0] a_s2;
    logic [2:0] b_s1;
    logic [2:0] b_s2;
    logic [2:0] xc_p;
    logic [2:0] a_p;
    logic [2:0] b_p;
    logic [31:0] prdata;
  } tmr_state_t;

endpackage : tmr_pkg

// File: rtl/tmr_ctrl.sv
// Three-channel timer control: sync, clock selection, commands, capture and waveform modes.
// Contract
// - Block sync write of one triggers all three channels in one cycle.
// - Line zero source: dedicated input zero, none, channel one A, channel two A.
// - Line one source: dedicated input one, none, channel zero A, channel two A.
// - Line two source: dedicated input two, none, channel zero A, channel one A.
// - Clock-on command enables the counter clock unless clock-off is also written.
// - Clock-off command disables the counter clock and beats clock-on.
// - Soft trigger command resets counter to zero and restarts a stopped clock, but does not enable a disabled one.
// - Clock source codes pick internal clocks one to five, then lines zero to two.
// - For line clock sources, invert zero counts rising edges, one counts falling edges.
// - Gate code 00 leaves clock free; others AND it with line zero, one, two.
// - Capture mode: stop-on-B-load stops the counter clock at each B load.
// - Capture mode: off-on-B-load disables the counter clock at each B load.
// - Capture trigger edge: none, rising, falling, both.
// - Trigger line select zero uses the B line, one the A line.
// - Capture mode C match trigger enable makes a C match reset and start.
// - Wave bit zero is capture mode, one is waveform mode.
// - Load-A field loads A on no, rising, falling or each A-line edge.
// - Load-B field loads B on no, rising, falling or each A-line edge.
// - Waveform mode: stop-on-C-match stops the counter clock at a C match.
// - Waveform mode: off-on-C-match disables the counter clock at a C match.
// - Registers A and B are writable only in waveform mode.
// - Count shape: up, up-down, up with C reset, up-down turning at C.
// - Output action codes: none, set, clear, toggle.
// - Event source: B line as input, or lines zero, one, two.
// - Event trigger enable makes the event reset and start the counter.
`timescale 1ns/100ps
`default_nettype none
`include "tmr_defs.svh"

module tmr_ctrl (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] dedicated_clk_in,
  input wire logic [2:0] wave_line_a_i,
  output logic [2:0] wave_line_a_o,
  output logic [2:0] wave_line_a_oe,
  input wire logic [2:0] wave_line_b_i,
  output logic [2:0] wave_line_b_o,
  output logic [2:0] wave_line_b_oe,
  output logic [2:0] clock_run
);

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] code, input logic rise, input logic fall);
    edge_hit = (code[0] & rise) | (code[1] & fall);
  endfunction : edge_hit

  function automatic logic act(input logic [1:0] code, input logic ev, input logic lvl);
    act = lvl;
    if (ev) begin
      unique case (code)
        2'b00: act = lvl;
        2'b01: act = 1'b1;
        2'b10: act = 1'b0;
        2'b11: act = ~lvl;
      endcase
    end
  endfunction : act

  function automatic logic xc_pick(input logic [1:0] code, input logic ded, input logic p, input logic q);
    unique case (code)
      2'b00: xc_pick = ded;
      2'b01: xc_pick = 1'b0;
      2'b10: xc_pick = p;
      2'b11: xc_pick = q;
    endcase
  endfunction : xc_pick

  tmr_pkg::tmr_state_t st_q;
  tmr_pkg::tmr_state_t st_d;
  logic [2:0] xc;
  logic [2:0] a_lvl;
  logic [2:0] b_lvl;
  logic [4:0] itick;
  logic [2:0] tick;
  logic [2:0] trig;
  logic [2:0] c_match;
  logic [2:0] ld_b;
  logic [2:0] sw_trg;
  logic wr;
  logic sync_trg;
  logic mapped;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    tmr_pkg::tmr_chan_t c;
    logic [31:0] m;
    logic [1:0] shape;
    logic [15:0] top;
    logic sel_edge;
    logic gate;
    logic ccr_hit;
    logic ext_trg;
    logic ev;
    logic tl;
    logic tl_p;
    logic evl;
    logic evl_p;
    logic a_m;
    logic b_m;
    logic ld_a;
    logic [31:0] rd;
    c = '0;
    m = '0;
    shape = '0;
    top = '0;
    sel_edge = 1'b0;
    gate = 1'b0;
    ccr_hit = 1'b0;
    ext_trg = 1'b0;
    ev = 1'b0;
    tl = 1'b0;
    tl_p = 1'b0;
    evl = 1'b0;
    evl_p = 1'b0;
    a_m = 1'b0;
    b_m = 1'b0;
    ld_a = 1'b0;
    rd = '0;
    tick = '0;
    trig = '0;
    c_match = '0;
    ld_b = '0;
    sw_trg = '0;
    st_d = st_q;
    // Pins are synchronised; only the second stage feeds any logic.
    st_d.clk_s1 = dedicated_clk_in;
    st_d.clk_s2 = st_q.clk_s1;
    st_d.a_s1 = wave_line_a_i;
    st_d.a_s2 = st_q.a_s1;
    st_d.b_s1 = wave_line_b_i;
    st_d.b_s2 = st_q.b_s1;
    st_d.div = st_q.div + 10'h001;
    itick[0] = &st_q.div[`TMR_DIV1_BITS-1:0];
    itick[1] = &st_q.div[`TMR_DIV2_BITS-1:0];
    itick[2] = &st_q.div[`TMR_DIV3_BITS-1:0];
    itick[3] = &st_q.div[`TMR_DIV4_BITS-1:0];
    itick[4] = &st_q.div[`TMR_DIV5_BITS-1:0];
    wr = psel & penable & pwrite;
    sync_trg = wr && (paddr == `TMR_ADR_BCR) && pwdata[`TMR_BCR_SYNC];
    if (wr && (paddr == `TMR_ADR_BMR)) begin
      st_d.ext_sel = pwdata[5:0];
    end
    for (int i = 0; i < 3; i++) begin
      a_lvl[i] = st_q.ch[i].mode[`TMR_M_WAVE] ? st_q.ch[i].a_out : st_q.a_s2[i];
      b_lvl[i] = (st_q.ch[i].mode[`TMR_M_WAVE] && (st_q.ch[i].mode[`TMR_M_EVSRC+:2] != 2'b00))
        ? st_q.ch[i].b_out : st_q.b_s2[i];
    end
    xc[0] = xc_pick(st_q.ext_sel[1:0], st_q.clk_s2[0], a_lvl[1], a_lvl[2]);
    xc[1] = xc_pick(st_q.ext_sel[3:2], st_q.clk_s2[1], a_lvl[0], a_lvl[2]);
    xc[2] = xc_pick(st_q.ext_sel[5:4], st_q.clk_s2[2], a_lvl[0], a_lvl[1]);
    st_d.xc_p = xc;
    st_d.a_p = a_lvl;
    st_d.b_p = b_lvl;
    mapped = (paddr == `TMR_ADR_BCR) || (paddr == `TMR_ADR_BMR);
    for (int i = 0; i < 3; i++) begin
      c = st_q.ch[i];
      m = c.mode;
      shape = m[`TMR_M_SHAPE+:2];
      if (m[`TMR_M_CLKSRC+:3] < 3'b101) begin
        sel_edge = itick[m[`TMR_M_CLKSRC+:3]];
      end else begin
        sel_edge = m[`TMR_M_INV]
          ? (~xc[m[`TMR_M_CLKSRC+:2] - 2'd1] & st_q.xc_p[m[`TMR_M_CLKSRC+:2] - 2'd1])
          : (xc[m[`TMR_M_CLKSRC+:2] - 2'd1] & ~st_q.xc_p[m[`TMR_M_CLKSRC+:2] - 2'd1]);
      end
      gate = (m[`TMR_M_GATE+:2] == 2'b00) | xc[m[`TMR_M_GATE+:2] - 2'd1];
      tick[i] = sel_edge & gate & c.clk_en & ~c.stopped;
      c_match[i] = tick[i] && (c.cv == c.rc);
      a_m = m[`TMR_M_WAVE] && tick[i] && (c.cv == c.ra);
      b_m = m[`TMR_M_WAVE] && tick[i] && (c.cv == c.rb);
      ccr_hit = wr && (paddr[7:6] == 2'(i)) && (paddr[5:0] == `TMR_OFS_CCR);
      sw_trg[i] = (ccr_hit && pwdata[`TMR_CCR_TRG]) || sync_trg;
      tl = m[`TMR_M_ABSEL] ? a_lvl[i] : b_lvl[i];
      tl_p = m[`TMR_M_ABSEL] ? st_q.a_p[i] : st_q.b_p[i];
      ext_trg = edge_hit(m[`TMR_M_EDGE+:2], tl & ~tl_p, ~tl & tl_p);
      if (m[`TMR_M_EVSRC+:2] == 2'b00) begin
        evl = b_lvl[i];
        evl_p = st_q.b_p[i];
      end else begin
        evl = xc[m[`TMR_M_EVSRC+:2] - 2'd1];
        evl_p = st_q.xc_p[m[`TMR_M_EVSRC+:2] - 2'd1];
      end
      ev = edge_hit(m[`TMR_M_EDGE+:2], evl & ~evl_p, ~evl & evl_p);
      if (!m[`TMR_M_WAVE]) begin
        trig[i] = sw_trg[i] | ext_trg | (m[`TMR_M_CTRG] & c_match[i]);
      end else begin
        trig[i] = sw_trg[i] | (ev & m[`TMR_M_EVTRG]) | ((shape == 2'b10) & c_match[i]);
      end
      if (trig[i]) begin
        c.cv = 16'h0000;
        c.up = 1'b1;
        c.a_loaded = 1'b0;
      end else if (tick[i]) begin
        top = shape[1] ? c.rc : 16'hFFFF;
        if (!m[`TMR_M_WAVE] || !shape[0]) begin
          c.cv = c.cv + 16'h0001;
        end else if (c.up) begin
          c.up = (c.cv < top);
          c.cv = c.up ? c.cv + 16'h0001 : c.cv - 16'h0001;
        end else begin
          c.up = (c.cv == 16'h0000);
          c.cv = c.up ? c.cv + 16'h0001 : c.cv - 16'h0001;
        end
      end
      // capture loads; B waits for an A load
      ld_a = !m[`TMR_M_WAVE] && edge_hit(m[`TMR_M_LDA+:2], a_lvl[i] & ~st_q.a_p[i], ~a_lvl[i] & st_q.a_p[i]);
      ld_b[i] = !m[`TMR_M_WAVE] && c.a_loaded
        && edge_hit(m[`TMR_M_LDB+:2], a_lvl[i] & ~st_q.a_p[i], ~a_lvl[i] & st_q.a_p[i]);
      if (ld_a) begin
        c.ra = st_q.ch[i].cv;
        c.a_loaded = 1'b1;
      end
      if (ld_b[i]) begin
        c.rb = st_q.ch[i].cv;
        c.a_loaded = 1'b0;
      end
      // trigger restarts a stopped clock only
      if (trig[i]) begin
        c.stopped = 1'b0;
      end
      if ((!m[`TMR_M_WAVE] && m[`TMR_M_STOP] && ld_b[i]) || (m[`TMR_M_WAVE] && m[`TMR_M_STOP] && c_match[i])) begin
        c.stopped = 1'b1;
      end
      if ((!m[`TMR_M_WAVE] && m[`TMR_M_OFF] && ld_b[i]) || (m[`TMR_M_WAVE] && m[`TMR_M_OFF] && c_match[i])) begin
        c.clk_en = 1'b0;
      end
      if (ccr_hit && pwdata[`TMR_CCR_ON] && !pwdata[`TMR_CCR_OFF]) begin
        c.clk_en = 1'b1;
        c.stopped = 1'b0;
      end
      if (ccr_hit && pwdata[`TMR_CCR_OFF]) begin
        c.clk_en = 1'b0;
      end
      // output actions, later events override earlier ones
      if (m[`TMR_M_WAVE]) begin
        c.a_out = act(m[`TMR_M_AMA+:2], a_m, c.a_out);
        c.a_out = act(m[`TMR_M_CMA+:2], c_match[i], c.a_out);
        c.a_out = act(m[`TMR_M_EVA+:2], ev, c.a_out);
        c.a_out = act(m[`TMR_M_SWA+:2], sw_trg[i], c.a_out);
        if (m[`TMR_M_EVSRC+:2] != 2'b00) begin
          c.b_out = act(m[`TMR_M_BMB+:2], b_m, c.b_out);
          c.b_out = act(m[`TMR_M_CMB+:2], c_match[i], c.b_out);
          c.b_out = act(m[`TMR_M_EVB+:2], ev, c.b_out);
          c.b_out = act(m[`TMR_M_SWB+:2], sw_trg[i], c.b_out);
        end
      end
      if (wr && (paddr[7:6] == 2'(i))) begin
        unique case (paddr[5:0])
          `TMR_OFS_CMR: c.mode = pwdata;
          // A and B writable in waveform mode only
          `TMR_OFS_RA: c.ra = m[`TMR_M_WAVE] ? pwdata[15:0] : c.ra;
          `TMR_OFS_RB: c.rb = m[`TMR_M_WAVE] ? pwdata[15:0] : c.rb;
          `TMR_OFS_RC: c.rc = pwdata[15:0];
          default: ;
        endcase
      end
      st_d.ch[i] = c;
      if (paddr[7:6] == 2'(i)) begin
        mapped = (paddr[5:0] == `TMR_OFS_CCR) || (paddr[5:0] == `TMR_OFS_CMR) || (paddr[5:0] == `TMR_OFS_CV)
          || (paddr[5:0] == `TMR_OFS_RA) || (paddr[5:0] == `TMR_OFS_RB) || (paddr[5:0] == `TMR_OFS_RC)
          || (paddr[5:0] == `TMR_OFS_SR);
        unique case (paddr[5:0])
          `TMR_OFS_CMR: rd = st_q.ch[i].mode;
          `TMR_OFS_CV: rd = {16'h0000, st_q.ch[i].cv};
          `TMR_OFS_RA: rd = {16'h0000, st_q.ch[i].ra};
          `TMR_OFS_RB: rd = {16'h0000, st_q.ch[i].rb};
          `TMR_OFS_RC: rd = {16'h0000, st_q.ch[i].rc};
          `TMR_OFS_SR: begin
            rd[`TMR_SR_CLKSTA] = st_q.ch[i].clk_en;
            rd[`TMR_SR_MLINE_A] = a_lvl[i];
            rd[`TMR_SR_MLINE_B] = b_lvl[i];
          end
          default: rd = '0;
        endcase
      end
    end
    if (paddr == `TMR_ADR_BMR) begin
      rd = {26'h0000000, st_q.ext_sel};
    end
    // Read data is caught in the setup cycle so that it leaves a flip-flop.
    if (psel && !penable) begin
      st_d.prdata = rd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign prdata = st_q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  generate
    for (genvar g = 0; g < 3; g++) begin : g_pins
      assign wave_line_a_o[g] = st_q.ch[g].a_out;
      assign wave_line_a_oe[g] = st_q.ch[g].mode[`TMR_M_WAVE];
      assign wave_line_b_o[g] = st_q.ch[g].b_out;
      assign wave_line_b_oe[g] = st_q.ch[g].mode[`TMR_M_WAVE] & (st_q.ch[g].mode[`TMR_M_EVSRC+:2] != 2'b00);
      assign clock_run[g] = st_q.ch[g].clk_en & ~st_q.ch[g].stopped;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence ccr0_wr(int b);
    wr && (paddr == 8'h00) && pwdata[b];
  endsequence

  sync_all_a: assert property (sync_trg |=> (st_q.ch[0].cv == 16'h0000)
    && (st_q.ch[1].cv == 16'h0000) && (st_q.ch[2].cv == 16'h0000))
    else $error("sync write did not clear all counters");
  line_zero_a: assert property ((st_q.ext_sel[1:0] == 2'b01) |-> !xc[0])
    else $error("line zero not idle for code 01");
  line_one_a: assert property ((st_q.ext_sel[3:2] == 2'b10) |-> (xc[1] == a_lvl[0]))
    else $error("line one not channel zero A");
  line_two_a: assert property ((st_q.ext_sel[5:4] == 2'b00) |-> (xc[2] == st_q.clk_s2[2]))
    else $error("line two not dedicated input two");
  clock_on_a: assert property (ccr0_wr(0) ##0 !pwdata[1] |=> st_q.ch[0].clk_en && clock_run[0])
    else $error("clock-on did not enable");
  clock_off_a: assert property (ccr0_wr(1) |=> !st_q.ch[0].clk_en && !clock_run[0])
    else $error("clock-off did not win");
  soft_trig_a: assert property (ccr0_wr(2) |=> (st_q.ch[0].cv == 16'h0000) && !st_q.ch[0].stopped)
    else $error("soft trigger did not reset and start");
  b_stop_a: assert property (ld_b[0] && st_q.ch[0].mode[`TMR_M_STOP] && !trig[0]
    && !(wr && paddr == 8'h00) |=> !clock_run[0])
    else $error("B load did not stop clock");
  c_off_a: assert property (c_match[2] && st_q.ch[2].mode[`TMR_M_WAVE] && st_q.ch[2].mode[`TMR_M_OFF]
    && !(wr && paddr == 8'h80) |=> !st_q.ch[2].clk_en)
    else $error("C match did not disable clock");
  ab_ro_a: assert property (wr && (paddr == 8'h54) && !st_q.ch[1].mode[`TMR_M_WAVE] && !$rose(a_lvl[1])
    && !$fell(a_lvl[1]) |=> $stable(st_q.ch[1].ra))
    else $error("register A written in capture mode");
  off_holds_a: assert property (!st_q.ch[0].clk_en && !(wr && paddr == 8'h00) |=> !st_q.ch[0].clk_en)
    else $error("disabled clock came back without command");

endmodule : tmr_ctrl
`default_nettype wire

// File: verification/tmr_pins_model.sv
// Far-side pin partner: dedicated clock sources and the far ends of the A and B lines.
`timescale 1ns/100ps
`default_nettype none

module tmr_pins_model (
  input wire logic [2:0] clk_req,
  input wire logic [2:0] a_req,
  input wire logic [2:0] b_req,
  input wire logic [2:0] a_o,
  input wire logic [2:0] a_oe,
  input wire logic [2:0] b_o,
  input wire logic [2:0] b_oe,
  output logic [2:0] dedicated_clk_in,
  output logic [2:0] a_lvl,
  output logic [2:0] b_lvl
);
  // The dedicated clocks stand still unless the bench asks for an edge.
  assign dedicated_clk_in = clk_req;
  // The far end drives a line only while the block has released it, so the two never fight.
  assign a_lvl = (a_oe & a_o) | (~a_oe & a_req);
  assign b_lvl = (b_oe & b_o) | (~b_oe & b_req);
endmodule : tmr_pins_model

`default_nettype wire

// File: verification/tmr_ctrl_tb_top.sv
// Self-checking bench of the timer control block.
`timescale 1ns/100ps
`default_nettype none

module tmr_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] clk_req = 3'h0;
  logic [2:0] a_req = 3'h0;
  logic [2:0] b_req = 3'h0;
  logic [2:0] ded_clk, a_o, a_oe, b_o, b_oe, a_lvl, b_lvl, clock_run;
  logic [31:0] rdat;
  logic [31:0] keep;
  logic serr;
  int err_count = 0;
  int n_checks = 0;
  localparam logic [7:0] CMD = 8'h00, MODE = 8'h04, CNT = 8'h10, REGA = 8'h14, REGC = 8'h1C, STAT = 8'h20;
  localparam logic [7:0] SYNC = 8'hC0, XSEL = 8'hC4;

  always #2 ref_clk = ~ref_clk;

  tmr_pins_model pins (.clk_req(clk_req), .a_req(a_req), .b_req(b_req), .a_o(a_o), .a_oe(a_oe), .b_o(b_o),
    .b_oe(b_oe), .dedicated_clk_in(ded_clk), .a_lvl(a_lvl), .b_lvl(b_lvl));
  tmr_ctrl dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dedicated_clk_in(ded_clk),
    .wave_line_a_i(a_lvl), .wave_line_a_o(a_o), .wave_line_a_oe(a_oe), .wave_line_b_i(b_lvl),
    .wave_line_b_o(b_o), .wave_line_b_oe(b_oe), .clock_run(clock_run));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  // The request is held until pready is seen high; the wait is bounded.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1);
      final_report();
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic pulse(input logic [2:0] ck, input logic [2:0] al, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      clk_req <= clk_req | ck;
      a_req <= a_req | al;
      repeat (6) @(posedge ref_clk);
      clk_req <= clk_req & ~ck;
      a_req <= a_req & ~al;
      repeat (6) @(posedge ref_clk);
    end
  endtask : pulse

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_regs;
    for (logic [7:0] o = 8'h10; o <= 8'h20; o += 8'h04) begin
      rd(o);
      chk(rdat, 32'h0);
    end
    rd(MODE);
    chk(rdat, 32'h0);
    rd(8'h08);
    chk({31'h0, serr}, 32'h1);
    wr(XSEL, 32'h39);
    rd(XSEL);
    chk(rdat, 32'h39);
  endtask : t_regs

  task automatic t_cmd;
    wr(CMD, 32'h1);
    repeat (40) @(posedge ref_clk);
    rd(CNT);
    chk({31'h0, rdat > 32'hF}, 32'h1);
    wr(MODE, 32'h4);
    wr(CMD, 32'h4);
    rd(CNT);
    chk({31'h0, rdat < 32'h2}, 32'h1);
    wr(CMD, 32'h0);
    rd(STAT);
    chk({31'h0, rdat[16]}, 32'h1);
    wr(CMD, 32'h3);
    rd(STAT);
    chk({31'h0, rdat[16]}, 32'h0);
    wr(CMD, 32'h4);
    @(negedge ref_clk);
    chk({31'h0, clock_run[0]}, 32'h0);
  endtask : t_cmd

  task automatic t_sync;
    for (int n = 0; n < 3; n++) begin
      wr(8'(64 * n) | MODE, 32'h0);
      wr(8'(64 * n) | CMD, 32'h1);
    end
    repeat (40) @(posedge ref_clk);
    for (int n = 0; n < 3; n++) wr(8'(64 * n) | MODE, 32'h4);
    wr(SYNC, 32'h0);
    for (int n = 0; n < 3; n++) begin
      rd(8'(64 * n) | CNT);
      chk({31'h0, rdat > 32'hF}, 32'h1);
    end
    wr(SYNC, 32'h1);
    for (int n = 0; n < 3; n++) begin
      rd(8'(64 * n) | CNT);
      chk({31'h0, rdat < 32'h2}, 32'h1);
    end
  endtask : t_sync

  // register A and B write access by mode
  task automatic t_ab;
    for (int m = 0; m < 2; m++) begin
      wr(8'h44, m ? 32'h8004 : 32'h0);
      for (int k = 0; k < 2; k++) begin
        wr(8'h54 + 8'(4 * k), 32'h1234);
        rd(8'h54 + 8'(4 * k));
        chk(rdat, m ? 32'h1234 : 32'h0);
      end
    end
    @(negedge ref_clk);
    chk({30'h0, a_oe[1], b_oe[1]}, 32'h2);
  endtask : t_ab

  task automatic t_cstop;
    wr(8'h80 | REGC, 32'h5);
    for (int j = 0; j < 2; j++) begin
      wr(8'h80 | MODE, j ? 32'h8080 : 32'h8040);
      wr(8'h80 | CMD, 32'h5);
      repeat (40) @(posedge ref_clk);
      chk({31'h0, clock_run[2]}, 32'h0);
      rd(8'h80 | STAT);
      chk({31'h0, rdat[16]}, j ? 32'h0 : 32'h1);
      wr(8'h80 | CMD, 32'h4);
      @(negedge ref_clk);
      chk({31'h0, clock_run[2]}, j ? 32'h0 : 32'h1);
    end
  endtask : t_cstop

  // soft trigger action on the A line
  task automatic t_out;
    logic exp;
    exp = 1'b0;
    for (int i = 0; i < 5; i++) begin
      logic [1:0] code;
      code = (i == 0) ? 2'h1 : (i == 1) ? 2'h2 : (i < 4) ? 2'h3 : 2'h0;
      exp = (code == 2'h1) ? 1'b1 : (code == 2'h2) ? 1'b0 : (code == 2'h3) ? ~exp : exp;
      wr(8'h44, 32'h8004 | (32'(code) << 22));
      wr(8'h40, 32'h5);
      repeat (3) @(negedge ref_clk);
      chk({31'h0, a_o[1]}, {31'h0, exp});
    end
  endtask : t_out

  task automatic t_ext;
    int src;
    // A far-side A line reaches a clock line only while its channel is in capture mode.
    wr(8'h44, 32'h0);
    wr(8'h84, 32'h0);
    for (int l = 0; l < 3; l++) begin
      for (int k = 0; k < 4; k++) begin
        src = (k == 2) ? (l == 0 ? 1 : 0) : (l == 2 ? 1 : 2);
        wr(XSEL, 32'(k) << (2 * l));
        wr(MODE, 32'(5 + l));
        wr(CMD, 32'h5);
        pulse(k < 2 ? 3'(1 << l) : 3'h0, k >= 2 ? 3'(1 << src) : 3'h0, 2);
        rd(CNT);
        chk(rdat, k == 1 ? 32'h0 : 32'h2);
      end
    end
    wr(XSEL, 32'h0);
    wr(MODE, 32'hD);
    wr(CMD, 32'h5);
    @(posedge ref_clk);
    clk_req <= 3'h1;
    repeat (8) @(posedge ref_clk);
    rd(CNT);
    chk(rdat, 32'h0);
    clk_req <= 3'h0;
    repeat (8) @(posedge ref_clk);
    rd(CNT);
    chk(rdat, 32'h1);
    wr(MODE, 32'h10);
    wr(CMD, 32'h5);
    repeat (30) @(posedge ref_clk);
    rd(CNT);
    chk(rdat, 32'h0);
    pulse(3'h1, 3'h0, 1);
    rd(CNT);
    chk({31'h0, rdat != 32'h0 && rdat < 32'h5}, 32'h1);
  endtask : t_ext

  // capture loads with stop or disable
  task automatic t_cap;
    for (int j = 0; j < 2; j++) begin
      wr(MODE, j ? 32'h90080 : 32'h90040);
      wr(CMD, 32'h5);
      repeat (20) @(posedge ref_clk);
      pulse(3'h0, 3'h1, 1);
      rd(REGA);
      keep = rdat;
      chk({31'h0, keep != 32'h0}, 32'h1);
      rd(8'h18);
      chk({31'h0, rdat > keep}, 32'h1);
      chk({31'h0, clock_run[0]}, 32'h0);
      rd(STAT);
      chk({31'h0, rdat[16]}, j ? 32'h0 : 32'h1);
    end
  endtask : t_cap

  // external trigger line choice and event trigger
  task automatic t_trg;
    for (int s = 0; s < 4; s++) begin
      wr(MODE, s < 2 ? 32'h100 | (32'(s) << 10) : 32'h8500 | (32'(s - 2) << 12));
      wr(CMD, 32'h5);
      repeat (60) @(posedge ref_clk);
      pulse(3'h1, 3'h1, 1);
      rd(CNT);
      chk({31'h0, rdat < 32'h14}, 32'(s % 2));
    end
  endtask : t_trg

  // C match reset in both views and the B line output
  task automatic t_wave;
    for (int w = 0; w < 3; w++) begin
      wr(8'h84, w == 0 ? 32'h0 : w == 1 ? 32'h4000 : 32'h8400C400);
      wr(8'h80, 32'h5);
      @(negedge ref_clk);
      chk({31'h0, b_o[2]}, 32'h0);
      repeat (40) @(posedge ref_clk);
      rd(8'h90);
      chk({31'h0, rdat < 32'h6}, {31'h0, w != 0});
    end
    chk({31'h0, b_o[2]}, 32'h1);
  endtask : t_wave

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_cmd();
    t_sync();
    t_ab();
    t_cstop();
    t_out();
    t_ext();
    t_cap();
    t_trg();
    t_wave();
    final_report();
  end
endmodule : tmr_ctrl_tb_top

`default_nettype wire
